// >>> common/bcc_defs.vh
// constants for the battery charge capacity counter
`ifndef BCC_DEFS_VH
`define BCC_DEFS_VH

// apb register byte offsets
`define BCC_OFS_CTRL     8'h00
`define BCC_OFS_STATUS   8'h04
`define BCC_OFS_NAC      8'h08
`define BCC_OFS_LMD      8'h0C
`define BCC_OFS_DCR      8'h10
`define BCC_OFS_PFC      8'h14

// control field positions and reset value
`define BCC_CTRL_DISP_EN 0
`define BCC_CTRL_SD_EN   1
`define BCC_CTRL_RESET   2'h3

// three-level strap codes
`define BCC_LVL_H        2'h0
`define BCC_LVL_Z        2'h1
`define BCC_LVL_L        2'h2

// full-count choices, index = strap1 code * 3 + strap2 code
`define BCC_PFC_0        16'h6A00
`define BCC_PFC_1        16'h5E00
`define BCC_PFC_2        16'hA200
`define BCC_PFC_3        16'h8900
`define BCC_PFC_4        16'h7000
`define BCC_PFC_5        16'hAF00
`define BCC_PFC_6        16'h7800
`define BCC_PFC_7        16'h9600
`define BCC_PFC_8        16'h3200

// converter pulses per count times 100 (efficiency in hundredths)
`define BCC_DIV_320      19'h07D00
`define BCC_DIV_640      19'h0FA00
`define BCC_DIV_1280     19'h1F400
`define BCC_DIV_2560     19'h3E800
`define BCC_EFF_UNITY    7'h64

// temperature range codes
`define BCC_TEMP_0C      4'h4
`define BCC_TEMP_30C     4'h7
`define BCC_TEMP_50C     4'h9

// self-discharge base shift below 10 degrees, and ticks per day as a shift
`define BCC_SD_SHIFT_H   5'h08
`define BCC_SD_SHIFT_Z   5'h09
`define BCC_SD_SHIFT_L   5'h0B
`define BCC_SD_TICK_LOG  5'h08

// timing
`define BCC_CLK_HZ       10000000
`define BCC_DISP_HOLD_S  4
`define BCC_DSG_HOLD_S   10
`define BCC_RATE_WIN_S   1
`define BCC_DAY_S        86400
`define BCC_STRAP_WAIT   3'h4

`endif

// >>> core/bcc_core.v
// counting core of the battery gas gauge with apb register access
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "bcc_defs.vh"

module bcc_core #(
    parameter [31:0] DISP_HOLD_CYC = `BCC_DISP_HOLD_S * `BCC_CLK_HZ,
    parameter [31:0] DSG_HOLD_CYC  = `BCC_DSG_HOLD_S * `BCC_CLK_HZ,
    parameter [31:0] RATE_WIN_CYC  = `BCC_RATE_WIN_S * `BCC_CLK_HZ,
    parameter [31:0] SD_TICK_CYC   = 32'hC92B_AE80
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // strap pins read with pull-up and with pull-down
    input  wire [5:0]  strap_up,
    input  wire [5:0]  strap_dn,
    // pins
    input  wire        charge_done,
    input  wire        button,
    // sense front end, on pclk
    input  wire        chg_pulse,
    input  wire        dsg_pulse,
    input  wire        above_250uv,
    input  wire        below_n250uv,
    input  wire        above_500uv,
    input  wire        below_n2mv,
    input  wire        first_empty_threshold,
    input  wire [3:0]  temp_range,
    // outputs to front end and display
    output reg         display_on,
    output reg         overload_sel,
    output reg         abs_mode,
    output reg  [15:0] full_ref,
    output reg  [1:0]  offset_sel,
    output reg         offset_apply
);

wire [13:0] pins_s;
reg  [1:0]  ctrl_reg;
reg  [2:0]  wait_reg;
reg         init_reg;
reg  [1:0]  s1_reg, s2_reg, s3_reg, s4_reg, s5_reg;
reg  [15:0] nac_reg, lmd_reg, dcr_reg, sdt_reg, pfc_reg;
reg  [18:0] chg_acc_reg, dsg_acc_reg;
reg  [24:0] sd_acc_reg;
reg  [31:0] sd_tmr_reg, win_reg, btn_tmr_reg, dsg_tmr_reg;
reg  [1:0]  upd_reg, win_cnt_reg;
reg         valid_reg, fast_reg, since_full_reg, empty_seen_reg;
reg         temp_ok_reg, vdq_reg, empty_d_reg;
reg  [6:0]  eff;
reg  [18:0] thr, chg_sum, dsg_sum;
reg  [24:0] sd_thr;
reg  [4:0]  sd_k;
reg  [15:0] lmd_floor, lmd_new;
reg         chg_step, dsg_step, sd_step, valid_start, learn, qualify, full;
reg  [31:0] rd_next;
reg         err_next;

// three-level decode: both reads high is H, pull-up read high alone is Z, otherwise L
function [1:0] lvl;
    input up;
    input dn;
    begin
        lvl = (up & dn) ? `BCC_LVL_H : (up ? `BCC_LVL_Z : `BCC_LVL_L);
    end
endfunction

// full-count table
function [15:0] pfc_of;
    input [3:0] idx;
    begin
        case (idx)
            4'h0:    pfc_of = `BCC_PFC_0;
            4'h1:    pfc_of = `BCC_PFC_1;
            4'h2:    pfc_of = `BCC_PFC_2;
            4'h3:    pfc_of = `BCC_PFC_3;
            4'h4:    pfc_of = `BCC_PFC_4;
            4'h5:    pfc_of = `BCC_PFC_5;
            4'h6:    pfc_of = `BCC_PFC_6;
            4'h7:    pfc_of = `BCC_PFC_7;
            default: pfc_of = `BCC_PFC_8;
        endcase
    end
endfunction

// pulses per count, derived from the same strap pair
function [18:0] div_of;
    input [3:0] idx;
    begin
        case (idx)
            4'h0, 4'h1:       div_of = `BCC_DIV_320;
            4'h2, 4'h3, 4'h4: div_of = `BCC_DIV_640;
            4'h5, 4'h6:       div_of = `BCC_DIV_1280;
            default:          div_of = `BCC_DIV_2560;
        endcase
    end
endfunction

// strap, done and button pin synchronisation; only true pins pass the three stages
bcc_sync #(
    .W(14)
) u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    ({button, charge_done, strap_dn, strap_up}),
    .level_out (pins_s)
);

// combinational counting decisions
always @* begin
    // efficiency by table, band and rate
    case (s5_reg)
        `BCC_LVL_H: begin
            if (temp_range < `BCC_TEMP_30C)
                eff = fast_reg ? 7'h5F : 7'h50;
            else if (temp_range < `BCC_TEMP_50C)
                eff = fast_reg ? 7'h5A : 7'h4B;
            else
                eff = fast_reg ? 7'h55 : 7'h46;
        end
        `BCC_LVL_L: begin
            if (temp_range < `BCC_TEMP_30C)
                eff = fast_reg ? 7'h5F : 7'h55;
            else if (temp_range < `BCC_TEMP_50C)
                eff = fast_reg ? 7'h5A : 7'h50;
            else
                eff = fast_reg ? 7'h55 : 7'h4B;
        end
        default: eff = `BCC_EFF_UNITY;
    endcase
    thr      = div_of({2'h0, s1_reg} * 4'h3 + {2'h0, s2_reg});
    chg_sum  = chg_acc_reg + {12'h0, eff};
    dsg_sum  = dsg_acc_reg + {12'h0, `BCC_EFF_UNITY};
    chg_step = init_reg & chg_pulse & above_250uv & (chg_sum >= thr);
    dsg_step = init_reg & dsg_pulse & below_n250uv & (dsg_sum >= thr);
    // self-discharge shift shrinks one per 10 degree step above code 4, by seven at most
    case (s3_reg)
        `BCC_LVL_H: sd_k = `BCC_SD_SHIFT_H;
        `BCC_LVL_Z: sd_k = `BCC_SD_SHIFT_Z;
        default:    sd_k = `BCC_SD_SHIFT_L;
    endcase
    if (temp_range > `BCC_TEMP_0C)
        sd_k = sd_k - ((temp_range > 4'hB) ? 5'h07 : {1'b0, temp_range - `BCC_TEMP_0C});
    sd_thr  = 25'h1 << (sd_k + `BCC_SD_TICK_LOG);
    sd_step = init_reg & ctrl_reg[`BCC_CTRL_SD_EN] & (sd_acc_reg >= sd_thr);
    full    = (nac_reg == lmd_reg);
    valid_start = chg_step & (upd_reg == 2'h2) & ~valid_reg;
    learn   = valid_start & empty_seen_reg;
    // self-discharge share kept under 6 percent of capacity
    qualify = ~since_full_reg & temp_ok_reg & vdq_reg &
              ({7'h0, sdt_reg} * 23'h64 < {7'h0, lmd_reg} * 23'h06);
    lmd_floor = lmd_reg - {2'h0, lmd_reg[15:2]};
    lmd_new   = (dcr_reg > lmd_floor) ? dcr_reg : lmd_floor;
end

// strap capture once the synchroniser has filled, then frozen
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wait_reg <= 3'h0;
        init_reg <= 1'b0;
        s1_reg   <= `BCC_LVL_H;
        s2_reg   <= `BCC_LVL_H;
        s3_reg   <= `BCC_LVL_H;
        s4_reg   <= `BCC_LVL_H;
        s5_reg   <= `BCC_LVL_H;
        offset_sel <= `BCC_LVL_H;
        pfc_reg  <= 16'h0;
    end else if (wait_reg != `BCC_STRAP_WAIT + 3'h2) begin
        wait_reg <= wait_reg + 3'h1;
        if (wait_reg == `BCC_STRAP_WAIT) begin
            init_reg   <= 1'b1;
            s1_reg     <= lvl(pins_s[0], pins_s[6]);
            s2_reg     <= lvl(pins_s[1], pins_s[7]);
            s3_reg     <= lvl(pins_s[2], pins_s[8]);
            s4_reg     <= lvl(pins_s[3], pins_s[9]);
            s5_reg     <= lvl(pins_s[4], pins_s[10]);
            offset_sel <= lvl(pins_s[5], pins_s[11]);
            pfc_reg    <= pfc_of({2'h0, lvl(pins_s[0], pins_s[6])} * 4'h3
                                 + {2'h0, lvl(pins_s[1], pins_s[7])});
        end
    end
end

// capacity, tally and learning state
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        nac_reg <= 16'h0;
        lmd_reg <= 16'h0;
        dcr_reg <= 16'h0;
        sdt_reg <= 16'h0;
        chg_acc_reg <= 19'h0;
        dsg_acc_reg <= 19'h0;
        upd_reg <= 2'h0;
        valid_reg <= 1'b0;
        since_full_reg <= 1'b0;
        empty_seen_reg <= 1'b0;
        empty_d_reg <= 1'b0;
        temp_ok_reg <= 1'b0;
        vdq_reg <= 1'b0;
    end else if (init_reg && wait_reg == `BCC_STRAP_WAIT + 3'h1) begin
        // first cycle after capture
        lmd_reg  <= pfc_reg;
        nac_reg  <= 16'h0;
    end else if (init_reg) begin
        if (chg_pulse & above_250uv)
            chg_acc_reg <= chg_step ? chg_sum - thr : chg_sum;
        if (dsg_pulse & below_n250uv)
            dsg_acc_reg <= dsg_step ? dsg_sum - thr : dsg_sum;
        // valid-charge tracking lasts while activity stays above 250uV
        if (!above_250uv) begin
            upd_reg   <= 2'h0;
            valid_reg <= 1'b0;
        end else if (chg_step && upd_reg != 2'h3) begin
            upd_reg <= upd_reg + 2'h1;
            if (upd_reg == 2'h2)
                valid_reg <= 1'b1;
        end
        // available count, one change per cycle, done takes priority
        if (pins_s[12])
            nac_reg <= lmd_reg;
        else if (learn)
            nac_reg <= 16'h0;
        else if (chg_step && nac_reg < lmd_reg)
            nac_reg <= nac_reg + 16'h1;
        else if ((dsg_step || sd_step) && nac_reg != 16'h0)
            nac_reg <= nac_reg - 16'h1;
        if (learn && qualify)
            lmd_reg <= lmd_new;
        // tally and self-discharge share; a step taken at full still counts
        if ((dsg_step || (sd_step && nac_reg != 16'h0)) && dcr_reg != 16'hFFFF)
            dcr_reg <= dcr_reg + 16'h1;
        else if (full)
            dcr_reg <= 16'h0;
        if (sd_step && nac_reg != 16'h0 && sdt_reg != 16'hFFFF)
            sdt_reg <= sdt_reg + 16'h1;
        else if (full)
            sdt_reg <= 16'h0;
        // charge between full and empty spoils the next learning
        if (full)
            since_full_reg <= 1'b0;
        else if (valid_start && !empty_seen_reg)
            since_full_reg <= 1'b1;
        // empty point and its temperature caught on the rising edge
        empty_d_reg <= first_empty_threshold;
        if (valid_start)
            empty_seen_reg <= 1'b0;
        else if (first_empty_threshold && !empty_d_reg && !empty_seen_reg) begin
            empty_seen_reg <= 1'b1;
            temp_ok_reg    <= (temp_range >= `BCC_TEMP_0C);
        end
        // done setting wins over the clear at learning
        if (pins_s[12])
            vdq_reg <= 1'b1;
        else if (learn)
            vdq_reg <= 1'b0;
    end
end

// self-discharge: each tick adds the count unless a step is taken in that cycle, a step per shifted fraction
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sd_tmr_reg <= 32'h0;
        sd_acc_reg <= 25'h0;
    end else if (init_reg && ctrl_reg[`BCC_CTRL_SD_EN]) begin
        sd_tmr_reg <= (sd_tmr_reg >= SD_TICK_CYC - 32'h1) ? 32'h0 : sd_tmr_reg + 32'h1;
        if (sd_step)
            sd_acc_reg <= sd_acc_reg - sd_thr;
        else if (sd_tmr_reg == 32'h0)
            sd_acc_reg <= sd_acc_reg + {9'h0, nac_reg};
    end
end

// fast charge means two or more counts in the last one-second window
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        win_reg     <= 32'h0;
        win_cnt_reg <= 2'h0;
        fast_reg    <= 1'b0;
    end else if (win_reg >= RATE_WIN_CYC - 32'h1) begin
        win_reg     <= 32'h0;
        fast_reg    <= (win_cnt_reg == 2'h2);
        win_cnt_reg <= 2'h0;
    end else begin
        win_reg <= win_reg + 32'h1;
        if (chg_step && win_cnt_reg != 2'h2)
            win_cnt_reg <= win_cnt_reg + 2'h1;
    end
end

// display timers and front-end steering outputs
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        btn_tmr_reg  <= 32'h0;
        dsg_tmr_reg  <= 32'h0;
        display_on   <= 1'b0;
        overload_sel <= 1'b0;
        abs_mode     <= 1'b0;
        full_ref     <= 16'h0;
        offset_apply <= 1'b0;
    end else begin
        if (pins_s[13])
            btn_tmr_reg <= DISP_HOLD_CYC;
        else if (btn_tmr_reg != 32'h0)
            btn_tmr_reg <= btn_tmr_reg - 32'h1;
        if (below_n2mv)
            dsg_tmr_reg <= DSG_HOLD_CYC;
        else if (dsg_tmr_reg != 32'h0)
            dsg_tmr_reg <= dsg_tmr_reg - 32'h1;
        display_on <= ctrl_reg[`BCC_CTRL_DISP_EN] & init_reg &
                      (pins_s[13] | btn_tmr_reg != 32'h0 | above_500uv |
                       below_n2mv | dsg_tmr_reg != 32'h0);
        overload_sel <= (s4_reg != `BCC_LVL_L);
        abs_mode     <= (s4_reg == `BCC_LVL_L);
        full_ref     <= (s4_reg == `BCC_LVL_L) ? pfc_reg : lmd_reg;
        offset_apply <= init_reg & (above_250uv | below_n250uv);
    end
end

// apb read mux, answered in the access phase with no wait
always @* begin
    rd_next  = 32'h0;
    err_next = 1'b0;
    case (paddr)
        `BCC_OFS_CTRL:   rd_next = {30'h0, ctrl_reg};
        `BCC_OFS_STATUS: rd_next = {14'h0, offset_sel, s5_reg, s4_reg, s3_reg,
                                    s2_reg, s1_reg, fast_reg, valid_reg, since_full_reg,
                                    empty_seen_reg, vdq_reg, init_reg};
        `BCC_OFS_NAC:    rd_next = {16'h0, nac_reg};
        `BCC_OFS_LMD:    rd_next = {16'h0, lmd_reg};
        `BCC_OFS_DCR:    rd_next = {16'h0, dcr_reg};
        `BCC_OFS_PFC:    rd_next = {16'h0, pfc_reg};
        default:         err_next = 1'b1;
    endcase
end

// apb slave; data and error are prepared in the setup cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_reg <= `BCC_CTRL_RESET;
        prdata   <= 32'h0;
        pready   <= 1'b0;
        pslverr  <= 1'b0;
    end else begin
        pready <= 1'b1;
        if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0 : rd_next;
            pslverr <= err_next;
        end
        if (psel && penable && pwrite && paddr == `BCC_OFS_CTRL)
            ctrl_reg <= pwdata[1:0];
    end
end

endmodule
`default_nettype wire

// >>> core/bcc_sync.v
// three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
`default_nettype none

module bcc_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // pins and clean levels
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] level_out
);

reg [W-1:0] s1_reg;
reg [W-1:0] s2_reg;
reg [W-1:0] s3_reg;
integer i;

// first stage is read only by the second; a bit changes once stages agree
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_reg    <= {W{1'b0}};
        s2_reg    <= {W{1'b0}};
        s3_reg    <= {W{1'b0}};
        level_out <= {W{1'b0}};
    end else begin
        s1_reg <= pin_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        for (i = 0; i < W; i = i + 1) begin
            if (s2_reg[i] == s3_reg[i]) begin
                level_out[i] <= s3_reg[i];
            end
        end
    end
end

endmodule
`default_nettype wire

// >>> verification/bcc_core_monitor.sv
// port checker for the charge capacity counter
`timescale 1ns/1ps
`default_nettype none
module bcc_core_monitor (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins, comparators and decoded outputs
    input wire logic        button,
    input wire logic        above_250uv,
    input wire logic        below_n250uv,
    input wire logic        below_n2mv,
    input wire logic        display_on,
    input wire logic        overload_sel,
    input wire logic        abs_mode,
    input wire logic [15:0] full_ref,
    input wire logic [1:0]  offset_sel,
    input wire logic        offset_apply
);
    logic [3:0] age_reg;
    logic       settled;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles since reset, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_reg <= 4'h0;
        end else if (age_reg != 4'hF) begin
            age_reg <= age_reg + 4'h1;
        end
    end
    assign settled = (age_reg > 4'h9);
    // setup cycles split by whether the address decodes
    sequence s_setup_bad;
        psel && !penable && (paddr > 8'h14 || paddr[1:0] != 2'h0);
    endsequence
    sequence s_setup_good;
        psel && !penable && paddr <= 8'h14 && paddr[1:0] == 2'h0;
    endsequence
    // display release events that start a hold period
    sequence s_dsg_release;
        display_on && $fell(below_n2mv);
    endsequence
    sequence s_btn_release;
        display_on && $fell(button);
    endsequence
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_bad_addr: assert property (s_setup_bad |=> pslverr && prdata == 32'h0)
        else $error("unmapped address not refused");
    a_good_addr: assert property (s_setup_good |=> !pslverr)
        else $error("mapped address refused");
    a_straps_held: assert property (settled |-> $stable(abs_mode) && $stable(overload_sel) && $stable(offset_sel))
        else $error("strap decode changed after capture");
    a_overload_mode: assert property (settled |-> overload_sel == !abs_mode)
        else $error("overload threshold does not match display mode");
    a_abs_reference: assert property (settled && abs_mode |-> $stable(full_ref))
        else $error("absolute reference moved");
    a_offset_gate: assert property (settled |-> offset_apply == $past(above_250uv || below_n250uv))
        else $error("offset apply does not follow dead band");
    a_dsg_hold: assert property (s_dsg_release |-> display_on [*8])
        else $error("display dropped right after discharge ended");
    a_btn_hold: assert property (s_btn_release |-> display_on [*8])
        else $error("display dropped right after button release");
endmodule
bind bcc_core bcc_core_monitor bcc_core_monitor_inst (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .paddr        (paddr),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .button       (button),
    .above_250uv  (above_250uv),
    .below_n250uv (below_n250uv),
    .below_n2mv   (below_n2mv),
    .display_on   (display_on),
    .overload_sel (overload_sel),
    .abs_mode     (abs_mode),
    .full_ref     (full_ref),
    .offset_sel   (offset_sel),
    .offset_apply (offset_apply)
);
`default_nettype wire

// >>> verification/bcc_front_model.sv
// sense converter, comparators and strap pins in front of the counter
`timescale 1ns/1ps
`default_nettype none
module bcc_front_model #(
    parameter logic [11:0] STRAP_CODES = 12'h580
) (
    // sense level in microvolts and converter run enable
    input wire logic signed [15:0] sense_uv,
    input wire logic               pulse_en,
    // converter counts and comparator levels
    output logic                   chg_pulse,
    output logic                   dsg_pulse,
    output logic                   above_250uv,
    output logic                   below_n250uv,
    output logic                   above_500uv,
    output logic                   below_n2mv,
    // strap pins read with pull-up and with pull-down
    output logic [5:0]             strap_up,
    output logic [5:0]             strap_dn
);
    // the converter counts any nonzero level; only comparators gate it
    assign chg_pulse    = pulse_en && sense_uv > 0;
    assign dsg_pulse    = pulse_en && sense_uv < 0;
    assign above_250uv  = sense_uv > 250;
    assign below_n250uv = sense_uv < -250;
    assign above_500uv  = sense_uv > 500;
    assign below_n2mv   = sense_uv < -2000;
    // code 0 high, 1 floating, 2 low: floating reads its pull
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            strap_up[i] = STRAP_CODES[2*i +: 2] != 2'h2;
            strap_dn[i] = STRAP_CODES[2*i +: 2] == 2'h0;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_bcc_core.sv
// self-checking bench for the charge capacity counter
`timescale 1ns/1ps
`default_nettype none
module tb_bcc_core;
    localparam logic [31:0] FULL = 32'h6A00;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic               charge_done, button, chg_pulse, dsg_pulse, above_250uv;
    logic               below_n250uv, above_500uv, below_n2mv, first_empty_threshold;
    logic               display_on, overload_sel, abs_mode, offset_apply, pulse_en, disp_seen;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata;
    logic [5:0]         strap_up, strap_dn;
    logic [3:0]         temp_range;
    logic [15:0]        full_ref;
    logic [1:0]         offset_sel;
    logic signed [15:0] sense_uv;
    int                 errors = 0, total_checks = 0;

    bcc_core #(.DISP_HOLD_CYC(32'h28), .DSG_HOLD_CYC(32'h64), .RATE_WIN_CYC(32'h32),
               .SD_TICK_CYC(32'h40)) bcc_core_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strap_up(strap_up), .strap_dn(strap_dn),
        .charge_done(charge_done), .button(button), .chg_pulse(chg_pulse),
        .dsg_pulse(dsg_pulse), .above_250uv(above_250uv), .below_n250uv(below_n250uv),
        .above_500uv(above_500uv), .below_n2mv(below_n2mv),
        .first_empty_threshold(first_empty_threshold), .temp_range(temp_range),
        .display_on(display_on), .overload_sel(overload_sel), .abs_mode(abs_mode),
        .full_ref(full_ref), .offset_sel(offset_sel), .offset_apply(offset_apply));

    // straps: 1,2,3 high, 4 low (absolute), 5 and 6 floating
    bcc_front_model #(.STRAP_CODES(12'h580)) bcc_front_model_inst (
        .sense_uv(sense_uv), .pulse_en(pulse_en), .chg_pulse(chg_pulse),
        .dsg_pulse(dsg_pulse), .above_250uv(above_250uv), .below_n250uv(below_n250uv),
        .above_500uv(above_500uv), .below_n2mv(below_n2mv), .strap_up(strap_up),
        .strap_dn(strap_dn));

    // 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask

    // one apb transfer; request held until ready is sampled high
    task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                            output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n == 50) begin
            errors++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] rd;
        logic        e;
        apb_xfer(a, 1'b0, 32'h0, rd, e);
        chk(nm, exp, rd);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb_xfer(a, 1'b1, d, rd, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // run the converter for n pulses at one sense level
    task automatic drive(input int uv, input int n);
        @(posedge pclk);
        sense_uv <= 16'(uv);
        pulse_en <= 1'b1;
        repeat (n) @(posedge pclk);
        disp_seen = display_on;
        sense_uv <= 16'sh0;
        pulse_en <= 1'b0;
        idle(10);
    endtask

    task automatic done_pulse;
        charge_done <= 1'b1;
        idle(10);
        charge_done <= 1'b0;
        idle(10);
    endtask

    // hang guard
    initial begin
        idle(100000);
        errors++;
        close_out();
    end

    initial begin
        logic [31:0] rd;
        logic [31:0] rd2;
        logic        e;
        {presetn, psel, penable, pwrite, charge_done, button, pulse_en} = 7'h00;
        {first_empty_threshold, disp_seen} = 2'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sense_uv = 16'sh0;
        temp_range = 4'h4;
        idle(20);
        presetn <= 1'b1;
        idle(10);
        rd_chk(8'h14, FULL, "full_count");
        rd_chk(8'h0C, FULL, "learned");
        rd_chk(8'h08, 32'h0, "count");
        rd_chk(8'h10, 32'h0, "tally");
        rd_chk(8'h00, 32'h3, "ctrl");
        apb_xfer(8'h04, 1'b0, 32'h0, rd, e);
        chk("strap_codes", 32'h16001, rd & 32'h3FFC1);
        chk("strap_outs", 32'h9, 32'({abs_mode, overload_sel, offset_sel}));
        chk("abs_ref", FULL, 32'(full_ref));
        wr(8'h08, 32'h1234);
        rd_chk(8'h08, 32'h0, "count_ro");
        apb_xfer(8'h18, 1'b0, 32'h0, rd, e);
        chk("unmapped_err", 32'h1, 32'(e));
        chk("unmapped_data", 32'h0, rd);
        $display("test reset done");
        // display on, self-discharge off so counts stay exact
        wr(8'h00, 32'h1);
        done_pulse();
        rd_chk(8'h08, FULL, "count_done");
        rd_chk(8'h10, 32'h0, "tally_full");
        apb_xfer(8'h04, 1'b0, 32'h0, rd, e);
        chk("qualified", 32'h2, rd & 32'h2);
        drive(-100, 400);
        drive(100, 400);
        rd_chk(8'h08, FULL, "count_deadband");
        drive(-300, 320);
        rd_chk(8'h08, FULL - 1, "count_dsg");
        rd_chk(8'h10, 32'h1, "tally_dsg");
        drive(600, 640);
        chk("disp_chg", 32'h1, 32'(disp_seen));
        rd_chk(8'h08, FULL, "count_clamp");
        rd_chk(8'h10, 32'h0, "tally_clear");
        $display("test counting done");
        wr(8'h00, 32'h3);
        idle(2000);
        wr(8'h00, 32'h1);
        apb_xfer(8'h08, 1'b0, 32'h0, rd, e);
        apb_xfer(8'h10, 1'b0, 32'h0, rd2, e);
        chk("sd_sum", FULL, rd + rd2);
        chk("sd_moved", 32'h1, 32'(rd < FULL));
        $display("test self discharge done");
        done_pulse();
        drive(-2500, 960);
        chk("disp_dsg", 32'h1, 32'(disp_seen));
        idle(85);
        chk("disp_hold", 32'h1, 32'(display_on));
        idle(20);
        chk("disp_off", 32'h0, 32'(display_on));
        rd_chk(8'h08, FULL - 3, "count_three");
        rd_chk(8'h10, 32'h3, "tally_three");
        button <= 1'b1;
        idle(10);
        button <= 1'b0;
        idle(30);
        chk("btn_hold", 32'h1, 32'(display_on));
        idle(30);
        chk("btn_off", 32'h0, 32'(display_on));
        $display("test display done");
        // empty seen at the 0..10 C boundary, then a valid charge learns
        first_empty_threshold <= 1'b1;
        idle(5);
        drive(300, 960);
        first_empty_threshold <= 1'b0;
        rd_chk(8'h08, 32'h0, "count_learn");
        rd_chk(8'h0C, FULL - (FULL >> 2), "learned_floor");
        apb_xfer(8'h04, 1'b0, 32'h0, rd, e);
        chk("qual_clear", 32'h0, rd & 32'h2);
        chk("abs_ref_kept", FULL, 32'(full_ref));
        $display("test learning done");
        close_out();
    end
endmodule
`default_nettype wire
